// [hw/spg_pin_latch.sv]
// pin hold latches with release to port or peripheral control
`timescale 1ns/100ps
`default_nettype none
module spg_pin_latch (
    input wire logic clk,
    input wire logic srst,
    input wire logic hold,
    input wire logic [7:0] port_data,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] periph_en,
    input wire logic [7:0] periph_data,
    input wire logic [7:0] periph_oe,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_owner_periph
);
    logic [7:0] out_reg, out_next;
    logic [7:0] oe_reg, oe_next;
    logic [7:0] own_reg, own_next;

    //////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < spg_pkg::NUM_PINS; g = g + 1) begin : g_pin
            always_comb begin
                if (hold) begin
                    // held pins keep the last driven state
                    out_next[g] = out_reg[g];
                    oe_next[g] = oe_reg[g];
                    own_next[g] = own_reg[g];
                end else if (periph_en[g]) begin
                    out_next[g] = periph_data[g];
                    oe_next[g] = periph_oe[g];
                    own_next[g] = 1'b1;
                end else begin
                    // cleared port regs give reset-default state
                    out_next[g] = port_data[g];
                    oe_next[g] = port_dir[g];
                    own_next[g] = 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            out_reg <= spg_pkg::PORT_RESET;
            oe_reg <= spg_pkg::PORT_RESET;
            own_reg <= spg_pkg::PORT_RESET;
        end else begin
            out_reg <= out_next;
            oe_reg <= oe_next;
            own_reg <= own_next;
        end
    end

    assign pin_out = out_reg;
    assign pin_oe = oe_reg;
    assign pin_owner_periph = own_reg;

    //////////////////////////////////////////////////////////////////
    a_hold_keeps: assert property (@(posedge clk) disable iff (srst)
        $past(hold) |-> pin_out == $past(pin_out) && pin_oe == $past(pin_oe))
        else $error("held pin changed");
    a_port_owns: assert property (@(posedge clk) disable iff (srst)
        (!hold && !periph_en[0]) |=> (pin_owner_periph[0] == 1'b0 && pin_oe[0] == $past(port_dir[0])))
        else $error("port did not take pin");
    a_reset_state: assert property (@(posedge clk) disable iff (srst)
        (!hold && periph_en == 8'h00 && port_dir == 8'h00) |=> pin_oe == 8'h00)
        else $error("pins not released to inputs");
endmodule : spg_pin_latch
`default_nettype wire

// [hw/spg_stop_gating.sv]
// stop-mode peripheral clock gating and power-state control
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - unrestored cleared port registers leave pins in reset-default state at release.
// - released pin with disabled peripheral is driven by port control registers.
// - any stop mode gates off the peripheral clocks.
// - debug enable keeps debug clock in light stop only; peripheral clocks still stop.
// - light stop keeps converter on only with async clock and voltage detect.
// - light stop keeps clock generator on only with both reference enables.
// - both stop modes keep real-time clock on only if enabled before entry.
// - light stop keeps regulator on only with voltage detect or debug enabled.
module spg_stop_gating (
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] stop_req,
    input wire logic wake,
    input wire logic powerdown_release_ack,
    input wire logic debug_mode_enable,
    input wire logic internal_ref_clock_enable,
    input wire logic internal_ref_stop_enable,
    input wire logic adc_async_clock_enable,
    input wire logic low_voltage_detect_enable,
    input wire logic rtc_enable,
    input wire logic [7:0] port_data,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] periph_en,
    input wire logic [7:0] periph_data,
    input wire logic [7:0] periph_oe,
    output logic periph_clk_en,
    output logic debug_clk_en,
    output logic [1:0] cpu_pwr,
    output logic [1:0] ram_pwr,
    output logic [1:0] flash_pwr,
    output logic [1:0] port_reg_pwr,
    output logic [1:0] periph_pwr,
    output logic [1:0] comparator_pwr,
    output logic [1:0] adc_pwr,
    output logic [1:0] clock_gen_pwr,
    output logic [1:0] oscillator_pwr,
    output logic [1:0] rtc_pwr,
    output logic [1:0] regulator_pwr,
    output logic [1:0] debug_pwr,
    output logic [1:0] voltage_detect_pwr,
    output logic io_hold,
    output logic [1:0] stop_status,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_owner_periph
);
    spg_pkg::spg_state_e state_reg, state_next;
    logic rtc_armed_reg, rtc_armed_next;
    logic pclk_reg, dclk_reg, hold_reg;
    logic pclk_next, dclk_next, hold_next;
    logic [1:0] cpu_reg, ram_reg, flash_reg, port_reg, per_reg, cmp_reg, adc_reg;
    logic [1:0] cg_reg, osc_reg, rtc_reg, vreg_reg, dbg_reg, vdet_reg, status_reg;
    logic [1:0] cpu_next, ram_next, flash_next, port_next, per_next, cmp_next, adc_next;
    logic [1:0] cg_next, osc_next, rtc_next, vreg_next, dbg_next, vdet_next, status_next;

    // condition to power state, used for every optional unit
    function automatic logic [1:0] opt_pwr(input logic keep);
        opt_pwr = keep ? spg_pkg::PWR_ON : spg_pkg::PWR_STANDBY;
    endfunction : opt_pwr

    //////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        rtc_armed_next = rtc_armed_reg;
        case (state_reg)
            spg_pkg::SPG_RUN: begin
                // rtc enable sampled at entry, so a late write cannot wake it
                rtc_armed_next = rtc_enable;
                if (stop_req == spg_pkg::MODE_LIGHT) begin
                    state_next = spg_pkg::SPG_LIGHT;
                end else if (stop_req == spg_pkg::MODE_PPD) begin
                    state_next = spg_pkg::SPG_PPD;
                end
            end
            spg_pkg::SPG_LIGHT: begin
                if (wake) begin
                    state_next = spg_pkg::SPG_RUN;
                end
            end
            spg_pkg::SPG_PPD: begin
                if (wake) begin
                    state_next = spg_pkg::SPG_WAKE;
                end
            end
            spg_pkg::SPG_WAKE: begin
                // pins stay latched until software acknowledges
                if (powerdown_release_ack) begin
                    state_next = spg_pkg::SPG_RUN;
                end
            end
            default: begin
                state_next = spg_pkg::SPG_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= spg_pkg::SPG_RUN;
            rtc_armed_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rtc_armed_reg <= rtc_armed_next;
        end
    end

    //////////////////////////////////////////////////////////////////
    always_comb begin
        pclk_next = 1'b1;
        dclk_next = 1'b1;
        hold_next = 1'b0;
        status_next = spg_pkg::MODE_RUN;
        cpu_next = spg_pkg::PWR_ON;
        ram_next = spg_pkg::PWR_ON;
        flash_next = spg_pkg::PWR_ON;
        port_next = spg_pkg::PWR_ON;
        per_next = spg_pkg::PWR_ON;
        cmp_next = spg_pkg::PWR_ON;
        adc_next = spg_pkg::PWR_ON;
        cg_next = spg_pkg::PWR_ON;
        osc_next = spg_pkg::PWR_ON;
        rtc_next = spg_pkg::PWR_ON;
        vreg_next = spg_pkg::PWR_ON;
        dbg_next = spg_pkg::PWR_ON;
        vdet_next = spg_pkg::PWR_ON;
        case (state_next)
            spg_pkg::SPG_LIGHT: begin
                pclk_next = 1'b0;
                dclk_next = debug_mode_enable;
                hold_next = 1'b1;
                status_next = spg_pkg::MODE_LIGHT;
                cpu_next = spg_pkg::PWR_STANDBY;
                ram_next = spg_pkg::PWR_STANDBY;
                flash_next = spg_pkg::PWR_STANDBY;
                port_next = spg_pkg::PWR_STANDBY;
                per_next = spg_pkg::PWR_STANDBY;
                cmp_next = spg_pkg::PWR_OFF;
                adc_next = opt_pwr(adc_async_clock_enable && low_voltage_detect_enable);
                cg_next = opt_pwr(internal_ref_clock_enable && internal_ref_stop_enable);
                osc_next = cg_next;
                rtc_next = opt_pwr(rtc_armed_next);
                vreg_next = opt_pwr(low_voltage_detect_enable || debug_mode_enable);
                dbg_next = opt_pwr(debug_mode_enable);
                vdet_next = opt_pwr(low_voltage_detect_enable);
            end
            spg_pkg::SPG_PPD, spg_pkg::SPG_WAKE: begin
                // wake keeps pins held while the core restarts
                pclk_next = (state_next == spg_pkg::SPG_WAKE);
                dclk_next = (state_next == spg_pkg::SPG_WAKE);
                hold_next = 1'b1;
                status_next = spg_pkg::MODE_PPD;
                if (state_next == spg_pkg::SPG_PPD) begin
                    cpu_next = spg_pkg::PWR_OFF;
                    ram_next = spg_pkg::PWR_STANDBY;
                    flash_next = spg_pkg::PWR_OFF;
                    port_next = spg_pkg::PWR_OFF;
                    per_next = spg_pkg::PWR_OFF;
                    cmp_next = spg_pkg::PWR_OFF;
                    adc_next = spg_pkg::PWR_OFF;
                    cg_next = spg_pkg::PWR_OFF;
                    osc_next = spg_pkg::PWR_OFF;
                    rtc_next = opt_pwr(rtc_armed_next);
                    vreg_next = spg_pkg::PWR_OFF;
                    dbg_next = spg_pkg::PWR_OFF;
                    vdet_next = spg_pkg::PWR_OFF;
                end
            end
            default: begin
                pclk_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pclk_reg <= 1'b1;
            dclk_reg <= 1'b1;
            hold_reg <= 1'b0;
            status_reg <= spg_pkg::MODE_RUN;
            cpu_reg <= spg_pkg::PWR_ON;
            ram_reg <= spg_pkg::PWR_ON;
            flash_reg <= spg_pkg::PWR_ON;
            port_reg <= spg_pkg::PWR_ON;
            per_reg <= spg_pkg::PWR_ON;
            cmp_reg <= spg_pkg::PWR_ON;
            adc_reg <= spg_pkg::PWR_ON;
            cg_reg <= spg_pkg::PWR_ON;
            osc_reg <= spg_pkg::PWR_ON;
            rtc_reg <= spg_pkg::PWR_ON;
            vreg_reg <= spg_pkg::PWR_ON;
            dbg_reg <= spg_pkg::PWR_ON;
            vdet_reg <= spg_pkg::PWR_ON;
        end else begin
            pclk_reg <= pclk_next;
            dclk_reg <= dclk_next;
            hold_reg <= hold_next;
            status_reg <= status_next;
            cpu_reg <= cpu_next;
            ram_reg <= ram_next;
            flash_reg <= flash_next;
            port_reg <= port_next;
            per_reg <= per_next;
            cmp_reg <= cmp_next;
            adc_reg <= adc_next;
            cg_reg <= cg_next;
            osc_reg <= osc_next;
            rtc_reg <= rtc_next;
            vreg_reg <= vreg_next;
            dbg_reg <= dbg_next;
            vdet_reg <= vdet_next;
        end
    end

    assign periph_clk_en = pclk_reg;
    assign debug_clk_en = dclk_reg;
    assign io_hold = hold_reg;
    assign stop_status = status_reg;
    assign cpu_pwr = cpu_reg;
    assign ram_pwr = ram_reg;
    assign flash_pwr = flash_reg;
    assign port_reg_pwr = port_reg;
    assign periph_pwr = per_reg;
    assign comparator_pwr = cmp_reg;
    assign adc_pwr = adc_reg;
    assign clock_gen_pwr = cg_reg;
    assign oscillator_pwr = osc_reg;
    assign rtc_pwr = rtc_reg;
    assign regulator_pwr = vreg_reg;
    assign debug_pwr = dbg_reg;
    assign voltage_detect_pwr = vdet_reg;

    //////////////////////////////////////////////////////////////////
    // latch bank sees hold_next, so pins freeze on the same edge that io_hold rises
    spg_pin_latch u_latch (
        .clk(clk),
        .srst(srst),
        .hold(hold_next),
        .port_data(port_data),
        .port_dir(port_dir),
        .periph_en(periph_en),
        .periph_data(periph_data),
        .periph_oe(periph_oe),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .pin_owner_periph(pin_owner_periph)
    );

    //////////////////////////////////////////////////////////////////
    a_stop_gates_clk: assert property (@(posedge clk) disable iff (srst)
        (stop_status != spg_pkg::MODE_RUN && io_hold && cpu_pwr != spg_pkg::PWR_ON) |-> !periph_clk_en)
        else $error("peripheral clock running in stop");
    a_debug_clk: assert property (@(posedge clk) disable iff (srst)
        (state_reg == spg_pkg::SPG_RUN && stop_req == spg_pkg::MODE_LIGHT && !wake)
        |=> (debug_clk_en == $past(debug_mode_enable)) && !periph_clk_en)
        else $error("debug clock wrong in light stop");
    a_adc_keep: assert property (@(posedge clk) disable iff (srst)
        (state_next == spg_pkg::SPG_LIGHT) |=>
        (adc_pwr == (($past(adc_async_clock_enable) && $past(low_voltage_detect_enable)) ? 2'h0 : 2'h1)))
        else $error("converter power wrong");
    a_clkgen_keep: assert property (@(posedge clk) disable iff (srst)
        (state_next == spg_pkg::SPG_LIGHT && !(internal_ref_clock_enable && internal_ref_stop_enable))
        |=> clock_gen_pwr == spg_pkg::PWR_STANDBY)
        else $error("clock generator not in standby");
    a_rtc_entry: assert property (@(posedge clk) disable iff (srst)
        (state_reg == spg_pkg::SPG_RUN && stop_req == spg_pkg::MODE_PPD && !rtc_enable)
        |=> rtc_pwr == spg_pkg::PWR_STANDBY)
        else $error("rtc running though disabled at entry");
    a_vreg_keep: assert property (@(posedge clk) disable iff (srst)
        (state_next == spg_pkg::SPG_LIGHT && (low_voltage_detect_enable || debug_mode_enable))
        |=> regulator_pwr == spg_pkg::PWR_ON)
        else $error("regulator dropped");
    a_ppd_off: assert property (@(posedge clk) disable iff (srst)
        (state_next == spg_pkg::SPG_PPD) |=>
        (cpu_pwr == spg_pkg::PWR_OFF && flash_pwr == spg_pkg::PWR_OFF && ram_pwr == spg_pkg::PWR_STANDBY && io_hold))
        else $error("partial power-down states wrong");
    a_ack_release: assert property (@(posedge clk) disable iff (srst)
        (state_reg == spg_pkg::SPG_WAKE && powerdown_release_ack) |=> !io_hold ##1 !io_hold || state_reg != spg_pkg::SPG_RUN)
        else $error("hold not released on ack");
    c_light: cover property (@(posedge clk) disable iff (srst) state_reg == spg_pkg::SPG_LIGHT ##[1:20] state_reg == spg_pkg::SPG_RUN);
    c_ppd_ack: cover property (@(posedge clk) disable iff (srst) state_reg == spg_pkg::SPG_WAKE && powerdown_release_ack);
    c_dbg: cover property (@(posedge clk) disable iff (srst) state_reg == spg_pkg::SPG_LIGHT && debug_clk_en);
endmodule : spg_stop_gating
`default_nettype wire

// [inc/spg_pkg.sv]
// package: stop-mode peripheral gating constants and types
`default_nettype none
package spg_pkg;
    // stop mode request encoding
    localparam logic [1:0] MODE_RUN = 2'h0;
    localparam logic [1:0] MODE_LIGHT = 2'h1;
    localparam logic [1:0] MODE_PPD = 2'h2;
    // unit power state encoding
    localparam logic [1:0] PWR_ON = 2'h0;
    localparam logic [1:0] PWR_STANDBY = 2'h1;
    localparam logic [1:0] PWR_OFF = 2'h2;
    // pin count of the latch bank
    localparam int NUM_PINS = 8;
    // reset values
    localparam logic [7:0] PORT_RESET = 8'h00;
    typedef enum logic [3:0] {
        SPG_RUN = 4'h1,
        SPG_LIGHT = 4'h2,
        SPG_PPD = 4'h4,
        SPG_WAKE = 4'h8
    } spg_state_e;
endpackage : spg_pkg
`default_nettype wire

// [verification/spg_stop_gating_test.sv]
// self-checking testbench for the stop-mode peripheral gating block
`timescale 1ns/100ps
`default_nettype none
module spg_stop_gating_test;
    localparam logic [1:0] P_ON = spg_pkg::PWR_ON;
    localparam logic [1:0] P_SB = spg_pkg::PWR_STANDBY;
    localparam logic [1:0] P_OF = spg_pkg::PWR_OFF;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [1:0] stop_req = 2'h0;
    logic wake = 1'b0;
    logic ack = 1'b0;
    logic dbg = 1'b0, irc = 1'b0, irs = 1'b0, adc_async = 1'b0, vdet = 1'b0, rtc = 1'b0;
    logic [7:0] port_data = 8'h00, port_dir = 8'h00, periph_en = 8'h00, periph_data = 8'h00, periph_oe = 8'h00;
    logic periph_clk_en, debug_clk_en, io_hold;
    logic [1:0] cpu_pwr, ram_pwr, flash_pwr, port_reg_pwr, periph_pwr, comparator_pwr, adc_pwr;
    logic [1:0] clock_gen_pwr, oscillator_pwr, rtc_pwr, regulator_pwr, debug_pwr, voltage_detect_pwr, stop_status;
    logic [7:0] pin_out, pin_oe, pin_owner_periph;
    logic [25:0] pwr;
    logic [25:0] all_on;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    assign pwr = {cpu_pwr, ram_pwr, flash_pwr, port_reg_pwr, periph_pwr, comparator_pwr, adc_pwr,
                  clock_gen_pwr, oscillator_pwr, rtc_pwr, regulator_pwr, debug_pwr, voltage_detect_pwr};
    assign all_on = 26'h0;
    always #10 clk = ~clk;
    spg_stop_gating i_dut (.clk(clk), .srst(srst), .stop_req(stop_req), .wake(wake),
        .powerdown_release_ack(ack), .debug_mode_enable(dbg), .internal_ref_clock_enable(irc),
        .internal_ref_stop_enable(irs), .adc_async_clock_enable(adc_async),
        .low_voltage_detect_enable(vdet), .rtc_enable(rtc), .port_data(port_data), .port_dir(port_dir),
        .periph_en(periph_en), .periph_data(periph_data), .periph_oe(periph_oe),
        .periph_clk_en(periph_clk_en), .debug_clk_en(debug_clk_en), .cpu_pwr(cpu_pwr), .ram_pwr(ram_pwr),
        .flash_pwr(flash_pwr), .port_reg_pwr(port_reg_pwr), .periph_pwr(periph_pwr),
        .comparator_pwr(comparator_pwr), .adc_pwr(adc_pwr), .clock_gen_pwr(clock_gen_pwr),
        .oscillator_pwr(oscillator_pwr), .rtc_pwr(rtc_pwr), .regulator_pwr(regulator_pwr),
        .debug_pwr(debug_pwr), .voltage_detect_pwr(voltage_detect_pwr), .io_hold(io_hold),
        .stop_status(stop_status),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_owner_periph(pin_owner_periph));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // inputs move a fixed 2 ns after the edge, outputs are settled by then
    task automatic tick();
        @(posedge clk);
        #2;
    endtask : tick
    // run-state checks shared by reset, wake and release
    task automatic chk_run();
        chk("status", {30'h0, spg_pkg::MODE_RUN}, {30'h0, stop_status});
        chk("clocks", 32'h3, {30'h0, periph_clk_en, debug_clk_en});
        chk("pwr", {6'h0, all_on}, {6'h0, pwr});
        chk("hold", 32'h0, {31'h0, io_hold});
    endtask : chk_run
    function automatic logic [25:0] light_exp(input logic a, input logic l, input logic c, input logic s,
                                              input logic r, input logic d);
        return {P_SB, P_SB, P_SB, P_SB, P_SB, P_OF, (a && l) ? P_ON : P_SB, (c && s) ? P_ON : P_SB,
                (c && s) ? P_ON : P_SB, r ? P_ON : P_SB, (l || d) ? P_ON : P_SB, d ? P_ON : P_SB,
                l ? P_ON : P_SB};
    endfunction : light_exp
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 5000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        repeat (5) tick();
        srst = 1'b0;
        chk_run();
        chk("reset pins", 32'h0, {8'h0, pin_owner_periph, pin_oe, pin_out});
        // code 3 is not a mode, nothing may change
        stop_req = 2'h3;
        tick();
        chk_run();
        // every combination of the six enables through light stop
        for (int i = 0; i < 64; i++) begin
            {dbg, irc, irs, adc_async, vdet, rtc} = i[5:0];
            stop_req = spg_pkg::MODE_LIGHT;
            tick();
            chk("light pwr", {6'h0, light_exp(adc_async, vdet, irc, irs, rtc, dbg)}, {6'h0, pwr});
            chk("light clocks", {30'h0, 1'b0, dbg}, {30'h0, periph_clk_en, debug_clk_en});
            chk("light status", {30'h0, spg_pkg::MODE_LIGHT}, {30'h0, stop_status});
            chk("light hold", 32'h1, {31'h0, io_hold});
            // other mode and release ack are refused while stopped
            stop_req = spg_pkg::MODE_PPD;
            ack = 1'b1;
            tick();
            chk("light refuse", {30'h0, spg_pkg::MODE_LIGHT}, {30'h0, stop_status});
            stop_req = spg_pkg::MODE_RUN;
            ack = 1'b0;
            wake = 1'b1;
            tick();
            wake = 1'b0;
            chk_run();
        end
        // partial power-down, rtc enabled and disabled before entry
        for (int r = 0; r < 2; r++) begin
            {dbg, irc, irs, adc_async, vdet, rtc} = {1'b0, 4'hf, r[0]};
            {port_dir, port_data, periph_en, periph_data, periph_oe} = {8'hff, 8'ha5, 24'h0};
            tick();
            tick();
            chk("run pins", 32'hffa5, {16'h0, pin_oe, pin_out});
            stop_req = spg_pkg::MODE_PPD;
            tick();
            stop_req = spg_pkg::MODE_RUN;
            chk("ppd pwr", {6'h0, P_OF, P_SB, P_OF, P_OF, P_OF, P_OF, P_OF, P_OF, P_OF,
                r[0] ? P_ON : P_SB, P_OF, P_OF, P_OF}, {6'h0, pwr});
            chk("ppd clocks", 32'h0, {30'h0, periph_clk_en, debug_clk_en});
            chk("ppd status", {30'h0, spg_pkg::MODE_PPD}, {30'h0, stop_status});
            // enable toggled in stop must not change the rtc, pins stay frozen, early ack refused
            rtc = ~rtc;
            port_data = 8'h5a;
            ack = 1'b1;
            tick();
            ack = 1'b0;
            chk("ppd rtc", {30'h0, r[0] ? P_ON : P_SB}, {30'h0, rtc_pwr});
            chk("ppd pins", 32'h1ffa5, {15'h0, io_hold, pin_oe, pin_out});
            chk("ppd refuse", {30'h0, spg_pkg::MODE_PPD}, {30'h0, stop_status});
            wake = 1'b1;
            tick();
            wake = 1'b0;
            chk("wake hold", {29'h0, 1'b1, spg_pkg::MODE_PPD}, {29'h0, io_hold, stop_status});
            chk("wake pins", 32'hffa5, {16'h0, pin_oe, pin_out});
            chk("wake clocks", 32'h3, {30'h0, periph_clk_en, debug_clk_en});
            chk("wake pwr", {6'h0, all_on}, {6'h0, pwr});
            // ports left cleared, low nibble handed back to an enabled peripheral
            {port_dir, port_data, periph_en, periph_data, periph_oe} = {16'h0, 8'h0f, 8'h3c, 8'h0f};
            ack = 1'b1;
            tick();
            ack = 1'b0;
            chk_run();
            tick();
            chk("owner", 32'h0f, {24'h0, pin_owner_periph});
            chk("pin oe", 32'h0f, {24'h0, pin_oe});
            chk("pin out", 32'h0c, {24'h0, pin_out});
            // port control of the released high nibble follows the port registers
            {port_dir, port_data} = 16'hf0a0;
            tick();
            tick();
            chk("port pins", 32'hffffac, {8'h0, pin_owner_periph ^ 8'hf0, pin_oe, pin_out});
        end
        // reset in the middle of partial power-down drops every held state
        stop_req = spg_pkg::MODE_PPD;
        tick();
        stop_req = spg_pkg::MODE_RUN;
        chk("ppd hold", 32'h1, {31'h0, io_hold});
        srst = 1'b1;
        repeat (2) tick();
        srst = 1'b0;
        chk_run();
        chk("rst pins", 32'h0, {8'h0, pin_owner_periph, pin_oe, pin_out});
        close_out();
    end
endmodule : spg_stop_gating_test
`default_nettype wire
